// ---- design/smc_defines.svh ----
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ==========================================================
// Transaction configuration word layout
`define SMC_DFS_MSB        3
`define SMC_DFS_LSB        0
`define SMC_FRF_MSB        5
`define SMC_FRF_LSB        4
`define SMC_CLOCK_PHASE_SEL_BIT       6
`define SMC_CLOCK_POLARITY_SEL_BIT      7
`define SMC_TRANSFER_MODE_SEL_MSB       9
`define SMC_TRANSFER_MODE_SEL_LSB       8

// ==========================================================
// Transfer modes and frame sizes
`define SMC_MODE_TXRX      2'h0
`define SMC_MODE_TX        2'h1
`define SMC_MODE_RX        2'h2
`define SMC_DFS_MIN        4'h3
`define SMC_FRAME_W        16
`define SMC_FIFO_DEPTH     32

// ==========================================================
// Reset values
`define SMC_IRQ_MASK_RST   5'h1F
`define SMC_CS_IDLE        16'hFFFF

// ==========================================================
// Serial clock limits, rates in MHz
`define SMC_SYS_MHZ        125
`define SMC_MAX_SCLK_MHZ   25
`define SMC_MIN_HALF ((`SMC_SYS_MHZ + 2 * `SMC_MAX_SCLK_MHZ - 1) / (2 * `SMC_MAX_SCLK_MHZ))

`endif

// ---- design/smc_pkg.sv ----
package smc_pkg;

	// ==========================================================
	// Shift engine states.
	typedef enum logic [1:0] {
		SMC_IDLE  = 2'b00,
		SMC_LOAD  = 2'b01,
		SMC_SHIFT = 2'b10,
		SMC_STOP  = 2'b11
	} smc_state_t;

	// Decoded transaction configuration.
	typedef struct packed {
		logic [1:0] mode;
		logic       cpol;
		logic       cpha;
		logic [1:0] frf;
		logic [3:0] frame_size_sel;
	} smc_cfg_t;

	// Interrupt source vector, receive level in bit 0.
	typedef struct packed {
		logic tx_level;
		logic tx_ovf;
		logic rx_under;
		logic rx_ovf;
		logic rx_level;
	} smc_irq_t;

endpackage : smc_pkg

// ---- design/smc_master.sv ----
`timescale 1ns/1ns
`include "smc_defines.svh"

// ==========================================================
// Frame FIFO
module smc_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	input  logic                   clock,
	input  logic                   rst,
	input  logic                   flush,
	input  logic                   in_valid,
	output logic                   in_ready,
	input  logic [W-1:0]           in_data,
	output logic                   out_valid,
	input  logic                   out_ready,
	output logic [W-1:0]           out_data,
	output logic [$clog2(D):0]     level
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_ff [D];
	logic [AW:0]  wr_ff;
	logic [AW:0]  rd_ff;

	// Pointer difference gives the fill level; depth is a power of two.
	assign level     = wr_ff - rd_ff;
	assign in_ready  = (level != (AW+1)'(D));
	assign out_valid = (level != '0);
	assign out_data  = mem_ff[rd_ff[AW-1:0]];

	// Write side.
	always_ff @(posedge clock) begin
		if (rst || flush) begin
			wr_ff <= '0;
		end else if (in_valid && in_ready) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
			wr_ff <= wr_ff + 1'b1;
		end
	end

	// Read side.
	always_ff @(posedge clock) begin
		if (rst || flush) begin
			rd_ff <= '0;
		end else if (out_valid && out_ready) begin
			rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule : smc_fifo

// ==========================================================
// Serial master controller
// Summary of operation
// - Exactly five interrupt sources exist.
// - Receive level interrupt is high while receive fill exceeds its threshold.
// - Receive overflow sets a sticky flag cleared by its clear strobe.
// - Popping an empty receive FIFO sets a sticky flag cleared by strobe.
// - Pushing a full transmit FIFO sets a sticky flag cleared by strobe.
// - Transmit level interrupt is high while transmit fill is below threshold.
// - Raw status readable, per-source mask all enabled at reset, masked view.
// - Interrupt output needs an enabled active source and controller enable.
// - Configuration word 0x10F selects 16-bit frames, transmit only.
// - Sixteen chip selects shared by slave interface, boot and master masks.
// - Force enable and force value override every chip select level.
// - Chip selects active low; select 0 also on a dedicated pin.
// - Enabled secondary subsystem may take chip selects 8 down to 5.
// - Frame size 4 to 16 bits, one frame per FIFO word.
// - Receive-only reads rx_frame_count plus one frames, started by one transmit write.
// - Chip select held for the whole transfer, ending when transmit FIFO empties, or in receive-only when the frame count runs out.
// - Divisor sets serial clock, limited to at most 25 MHz.
module smc_master #(
	parameter int DEPTH = `SMC_FIFO_DEPTH,
	parameter int FW    = `SMC_FRAME_W
) (
	input  logic                   clock,
	input  logic                   rst,
	input  logic                   controller_enable,
	input  logic [15:0]            transaction_config_reg,
	input  logic [15:0]            rx_frame_count,
	input  logic [15:0]            clock_divisor,
	input  logic [15:0]            cs_select_mask,
	input  logic [$clog2(DEPTH):0] tx_threshold,
	input  logic [$clog2(DEPTH):0] rx_threshold,
	input  logic                   irq_mask_we,
	input  smc_pkg::smc_irq_t      irq_mask_wdata,
	output smc_pkg::smc_irq_t      irq_mask,
	input  logic                   fifo_data_wr,
	input  logic [FW-1:0]          fifo_data_wdata,
	output logic                   fifo_data_wr_ready,
	input  logic                   fifo_data_rd,
	output logic [FW-1:0]          fifo_data_rdata,
	input  logic                   rx_overflow_clear,
	input  logic                   rx_underflow_clear,
	input  logic                   tx_overflow_clear,
	output smc_pkg::smc_irq_t      raw_irq_status,
	output smc_pkg::smc_irq_t      masked_irq_status,
	output logic                   irq_out,
	output logic [$clog2(DEPTH):0] tx_fill_level,
	output logic [$clog2(DEPTH):0] rx_fill_level,
	output logic                   busy,
	output logic                   tx_fifo_empty,
	output logic                   rx_fifo_not_empty,
	input  logic [15:0]            boot_cs_sel,
	input  logic [15:0]            slave_if_cs_sel,
	input  logic [15:0]            cs_force_enable,
	input  logic [15:0]            cs_force_value,
	input  logic                   subcpu_enable,
	input  logic [3:0]             subcpu_cs_n,
	output logic [15:0]            cs_pins_n,
	output logic                   primary_cs_pin_n,
	output logic                   sclk_out,
	output logic                   mosi_out,
	input  logic                   miso_in
);
	import smc_pkg::*;
	localparam int LW = $clog2(DEPTH) + 1;

	smc_cfg_t   cfg;
	smc_state_t state_ff;
	logic [FW-1:0] tx_data, rx_data, rx_sh_ff, shreg_ff, aligned;
	logic [15:0]   div_cnt_ff, half, frames_left_ff, nxt_cs_n;
	logic [4:0]    edge_ff, bits;
	logic          tx_valid, tx_pop, tx_ready, rx_ready, rx_valid, rx_push_ff;
	logic          tick, edge_last, frame_end, more, first_ff, rx_only;
	logic          miso_meta_ff, miso_ff, sclk_ff, mosi_ff;
	logic          rxo_ff, rxu_ff, txo_ff, irq_ff;

	// Frame length in bits, clamped to the shortest legal frame.
	function automatic logic [4:0] frame_bits(input logic [3:0] frame_size_sel);
		frame_bits = (frame_size_sel < `SMC_DFS_MIN) ? 5'h04 : 5'({1'b0, frame_size_sel}) + 5'h01;
	endfunction : frame_bits

	// ==========================================================
	// Configuration decode
	// config decode
	assign cfg.frame_size_sel  = transaction_config_reg[`SMC_DFS_MSB:`SMC_DFS_LSB];
	assign cfg.frf  = transaction_config_reg[`SMC_FRF_MSB:`SMC_FRF_LSB];
	assign cfg.cpha = transaction_config_reg[`SMC_CLOCK_PHASE_SEL_BIT];
	assign cfg.cpol = transaction_config_reg[`SMC_CLOCK_POLARITY_SEL_BIT];
	assign cfg.mode = transaction_config_reg[`SMC_TRANSFER_MODE_SEL_MSB:`SMC_TRANSFER_MODE_SEL_LSB];
	assign rx_only  = (cfg.mode == `SMC_MODE_RX);
	assign bits     = frame_bits(cfg.frame_size_sel);

	// ==========================================================
	// FIFOs
	// data port
	smc_fifo #(.W(FW), .D(DEPTH)) u_tx_fifo (
		.clock     (clock),
		.rst       (rst),
		.flush     (!controller_enable),
		.in_valid  (fifo_data_wr),
		.in_ready  (tx_ready),
		.in_data   (fifo_data_wdata),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_data),
		.level     (tx_fill_level)
	);

	smc_fifo #(.W(FW), .D(DEPTH)) u_rx_fifo (
		.clock     (clock),
		.rst       (rst),
		.flush     (!controller_enable),
		.in_valid  (rx_push_ff),
		.in_ready  (rx_ready),
		.in_data   (rx_sh_ff),
		.out_valid (rx_valid),
		.out_ready (fifo_data_rd),
		.out_data  (rx_data),
		.level     (rx_fill_level)
	);

	// Popped receive word is returned one cycle after the read strobe.
	always_ff @(posedge clock) begin
		if (rst) begin
			fifo_data_rdata <= '0;
		end else if (fifo_data_rd) begin
			fifo_data_rdata <= rx_valid ? rx_data : '0;
		end
	end

	assign fifo_data_wr_ready = tx_ready;
	assign tx_fifo_empty      = !tx_valid;
	assign rx_fifo_not_empty  = rx_valid;
	assign busy               = (state_ff != SMC_IDLE);

	// ==========================================================
	// Serial input synchroniser.
	always_ff @(posedge clock) begin
		if (rst) begin
			miso_meta_ff <= 1'b0;
			miso_ff      <= 1'b0;
		end else begin
			miso_meta_ff <= miso_in;
			miso_ff      <= miso_meta_ff;
		end
	end

	// ==========================================================
	// Serial clock divider
	// clock divide
	assign half = ((clock_divisor >> 1) < 16'(`SMC_MIN_HALF)) ? 16'(`SMC_MIN_HALF)
	            : (clock_divisor >> 1);
	assign tick = (div_cnt_ff == 16'h0000) && (state_ff[1] == 1'b1);

	// Half-period counter runs while shifting and during the closing gap.
	always_ff @(posedge clock) begin
		if (rst || !state_ff[1] || tick) begin
			div_cnt_ff <= half - 16'h0001;
		end else begin
			div_cnt_ff <= div_cnt_ff - 16'h0001;
		end
	end

	// ==========================================================
	// Transfer sequencing
	assign edge_last = (edge_ff == ((bits << 1) - 5'h01));
	assign frame_end = tick && (state_ff == SMC_SHIFT) && edge_last;
	assign more      = rx_only ? (frames_left_ff != 16'h0000) : tx_valid;
	assign tx_pop    = (state_ff == SMC_LOAD) && tx_valid && (!rx_only || first_ff);
	assign aligned   = (rx_only ? '0 : tx_data) << (5'(FW) - bits);

	always_ff @(posedge clock) begin
		if (rst || !controller_enable) begin
			state_ff <= SMC_IDLE;
		end else begin
			case (state_ff)
				SMC_IDLE:  state_ff <= tx_valid ? SMC_LOAD : SMC_IDLE;
				SMC_LOAD:  state_ff <= SMC_SHIFT;
				SMC_SHIFT: if (frame_end) begin
					state_ff <= more ? SMC_LOAD : SMC_STOP;
				end
				SMC_STOP:  state_ff <= tick ? SMC_IDLE : SMC_STOP;
				default:   state_ff <= SMC_IDLE;
			endcase
		end
	end

	// Receive-only frame counter and start-frame marker.
	always_ff @(posedge clock) begin
		if (rst) begin
			frames_left_ff <= '0;
			first_ff       <= 1'b0;
		end else if (state_ff == SMC_IDLE) begin
			frames_left_ff <= rx_frame_count;
			first_ff       <= 1'b1;
		end else begin
			if (state_ff == SMC_LOAD) begin
				first_ff <= 1'b0;
			end
			if (frame_end && rx_only && more) begin
				frames_left_ff <= frames_left_ff - 16'h0001;
			end
		end
	end

	// Shift engine: sample on one edge of each pair, drive on the other.
	always_ff @(posedge clock) begin
		if (rst) begin
			sclk_ff  <= 1'b0;
			mosi_ff  <= 1'b0;
			shreg_ff <= '0;
			rx_sh_ff <= '0;
			edge_ff  <= '0;
		end else if (state_ff == SMC_LOAD) begin
			sclk_ff  <= cfg.cpol;
			edge_ff  <= '0;
			rx_sh_ff <= '0;
			mosi_ff  <= cfg.cpha ? mosi_ff : aligned[FW-1];
			shreg_ff <= cfg.cpha ? aligned : (aligned << 1);
		end else if (tick && state_ff == SMC_SHIFT) begin
			sclk_ff <= ~sclk_ff;
			edge_ff <= edge_ff + 5'h01;
			if (edge_ff[0] == cfg.cpha) begin
				rx_sh_ff <= {rx_sh_ff[FW-2:0], miso_ff};
			end else begin
				mosi_ff  <= shreg_ff[FW-1];
				shreg_ff <= shreg_ff << 1;
			end
		end else if (state_ff != SMC_SHIFT) begin
			sclk_ff <= cfg.cpol;
		end
	end

	// Received frame is pushed the cycle after its last edge.
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_push_ff <= 1'b0;
		end else begin
			rx_push_ff <= frame_end && (cfg.mode != `SMC_MODE_TX);
		end
	end

	assign sclk_out = sclk_ff;
	assign mosi_out = mosi_ff;

	// ==========================================================
	// Chip selects
	// shared selects
	always_comb begin
		nxt_cs_n = ~(boot_cs_sel | slave_if_cs_sel
		           | (busy ? cs_select_mask : 16'h0000));
		if (subcpu_enable) begin
			nxt_cs_n[8:5] = subcpu_cs_n;
		end
		nxt_cs_n = (cs_force_enable & cs_force_value) | (~cs_force_enable & nxt_cs_n);
	end

	// Pins are driven from flip-flops, idle high out of reset.
	always_ff @(posedge clock) begin
		if (rst) begin
			cs_pins_n        <= `SMC_CS_IDLE;
			primary_cs_pin_n <= 1'b1;
		end else begin
			cs_pins_n        <= nxt_cs_n;
			primary_cs_pin_n <= nxt_cs_n[0];
		end
	end

	// ==========================================================
	// Interrupts
	// receive overflow, receive underflow and transmit overflow flags
	always_ff @(posedge clock) begin
		if (rst) begin
			rxo_ff <= 1'b0;
			rxu_ff <= 1'b0;
			txo_ff <= 1'b0;
		end else begin
			rxo_ff <= (rx_push_ff && !rx_ready) || (rxo_ff && !rx_overflow_clear);
			rxu_ff <= (fifo_data_rd && !rx_valid) || (rxu_ff && !rx_underflow_clear);
			txo_ff <= (fifo_data_wr && !tx_ready) || (txo_ff && !tx_overflow_clear);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_mask <= `SMC_IRQ_MASK_RST;
		end else if (irq_mask_we) begin
			irq_mask <= irq_mask_wdata;
		end
	end

	assign raw_irq_status.rx_level = (rx_fill_level > rx_threshold);
	assign raw_irq_status.rx_ovf   = rxo_ff;
	assign raw_irq_status.rx_under = rxu_ff;
	assign raw_irq_status.tx_ovf   = txo_ff;
	assign raw_irq_status.tx_level = (tx_fill_level < tx_threshold);
	assign masked_irq_status       = raw_irq_status & irq_mask;

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= controller_enable && (masked_irq_status != '0);
		end
	end
	assign irq_out = irq_ff;

	// ==========================================================
	// Checks
	chk_irq_gate: assert property (@(posedge clock) disable iff (rst)
		!controller_enable |=> !irq_out) else $error("irq asserted while disabled");
	chk_rxo_sticky: assert property (@(posedge clock) disable iff (rst)
		rxo_ff && !rx_overflow_clear |=> raw_irq_status.rx_ovf)
		else $error("receive overflow flag lost");
	chk_rxu_set: assert property (@(posedge clock) disable iff (rst)
		fifo_data_rd && !rx_fifo_not_empty |=> raw_irq_status.rx_under)
		else $error("underflow not flagged");
	chk_txo_set: assert property (@(posedge clock) disable iff (rst)
		fifo_data_wr && !fifo_data_wr_ready |=> raw_irq_status.tx_ovf)
		else $error("transmit overflow not flagged");
	chk_rx_level: assert property (@(posedge clock) disable iff (rst)
		raw_irq_status.rx_level && fifo_data_rd && !rx_push_ff && controller_enable
		&& (rx_fill_level == rx_threshold + 1'b1) |=> !raw_irq_status.rx_level)
		else $error("receive level irq did not drop");
	chk_tx_level: assert property (@(posedge clock) disable iff (rst)
		raw_irq_status.tx_level && fifo_data_wr && fifo_data_wr_ready && !tx_pop
		&& controller_enable && (tx_fill_level + 1'b1 == tx_threshold)
		|=> !raw_irq_status.tx_level)
		else $error("transmit level irq did not drop");
	chk_mask_reset: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> irq_mask == `SMC_IRQ_MASK_RST) else $error("mask not all enabled");
	chk_cs_force: assert property (@(posedge clock) disable iff (rst)
		cs_force_enable != 16'h0000 |=>
		((cs_pins_n ^ $past(cs_force_value)) & $past(cs_force_enable)) == 16'h0000)
		else $error("chip select force ignored");
	chk_cs_hold: assert property (@(posedge clock) disable iff (rst)
		busy && cs_select_mask[0] && !cs_force_enable[0] && !boot_cs_sel[0] |=> !cs_pins_n[0])
		else $error("chip select dropped mid transfer");
	chk_frame_push: assert property (@(posedge clock) disable iff (rst)
		frame_end && cfg.mode != `SMC_MODE_TX |=> rx_push_ff) else $error("frame not pushed");
	chk_rx_push_lands: assert property (@(posedge clock) disable iff (rst)
		rx_push_ff && rx_ready && !fifo_data_rd && controller_enable
		|=> rx_fill_level == $past(rx_fill_level) + 1'b1)
		else $error("received frame not stored");

	cov_tx_frame: cover property (@(posedge clock) disable iff (rst) frame_end);
	cov_rx_ovf: cover property (@(posedge clock) disable iff (rst) $rose(rxo_ff));
	cov_rx_only: cover property (@(posedge clock) disable iff (rst)
		rx_only && state_ff == SMC_STOP);
endmodule : smc_master

// ---- tb/smc_slave_model.sv ----
`timescale 1ns/1ns

// ==========================================================
// Serial slave model
module smc_slave_model (
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	input  wire logic [15:0] reply,
	output logic             miso,
	output logic [15:0]      captured,
	output int               bit_count
);
	logic [15:0] shreg;
	logic        sclk_q;
	logic        cs_q;

	// One process owns every output, so each line has a single driver.
	initial begin
		miso      = 1'b0;
		captured  = 16'h0000;
		bit_count = 0;
		shreg     = 16'h0000;
		sclk_q    = 1'b0;
		cs_q      = 1'b1;
		forever begin
			@(sclk or cs_n);
			if (cs_q === 1'b1 && cs_n === 1'b0) begin
				// Selection loads the reply word and restarts the bit count.
				bit_count = 0;
				shreg     = reply;
				miso      = reply[15];
			end else if (cs_q === 1'b0 && cs_n === 1'b1) begin
				// A released line shows the inverse of its last level.
				miso = ~miso;
			end else if (cs_n === 1'b0 && sclk_q === 1'b0 && sclk === 1'b1) begin
				// Mosi is captured on the leading edge, most significant bit first.
				captured  = {captured[14:0], mosi};
				bit_count = bit_count + 1;
			end else if (cs_n === 1'b0 && sclk_q === 1'b1 && sclk === 1'b0) begin
				// The next reply bit is launched on the trailing edge, reloaded every 16 bits.
				shreg = (bit_count % 16 == 0) ? reply : {shreg[14:0], 1'b0};
				miso  = shreg[15];
			end
			sclk_q = sclk;
			cs_q   = cs_n;
		end
	end
endmodule : smc_slave_model

// ---- tb/smc_master_tb.sv ----
`timescale 1ns/1ns

// ==========================================================
// Serial master controller testbench
module smc_master_tb;
	import smc_pkg::*;
	logic        clock, rst, controller_enable, irq_mask_we, fifo_data_wr, fifo_data_rd;
	logic        rx_overflow_clear, rx_underflow_clear, tx_overflow_clear, subcpu_enable;
	logic        fifo_data_wr_ready, irq_out, busy, tx_fifo_empty, rx_fifo_not_empty;
	logic        primary_cs_pin_n, sclk_out, mosi_out, miso_in;
	logic [15:0] transaction_config_reg, rx_frame_count, clock_divisor, cs_select_mask;
	logic [15:0] fifo_data_wdata, fifo_data_rdata, boot_cs_sel, slave_if_cs_sel;
	logic [15:0] cs_force_enable, cs_force_value, cs_pins_n, reply, captured, exp_cs;
	logic [5:0]  tx_threshold, rx_threshold, tx_fill_level, rx_fill_level;
	logic [3:0]  subcpu_cs_n;
	smc_irq_t    irq_mask_wdata, irq_mask, raw_irq_status, masked_irq_status;
	int          mismatches, check_count, bit_count, per;

	smc_master #(.DEPTH(32), .FW(16)) smc_master_i (.clock, .rst, .controller_enable,
		.transaction_config_reg, .rx_frame_count, .clock_divisor, .cs_select_mask,
		.tx_threshold, .rx_threshold, .irq_mask_we, .irq_mask_wdata, .irq_mask,
		.fifo_data_wr, .fifo_data_wdata, .fifo_data_wr_ready, .fifo_data_rd,
		.fifo_data_rdata, .rx_overflow_clear, .rx_underflow_clear, .tx_overflow_clear,
		.raw_irq_status, .masked_irq_status, .irq_out, .tx_fill_level, .rx_fill_level,
		.busy, .tx_fifo_empty, .rx_fifo_not_empty, .boot_cs_sel, .slave_if_cs_sel,
		.cs_force_enable, .cs_force_value, .subcpu_enable, .subcpu_cs_n, .cs_pins_n,
		.primary_cs_pin_n, .sclk_out, .mosi_out, .miso_in);

	smc_slave_model smc_slave_model_i (.sclk(sclk_out), .cs_n(cs_pins_n[0]), .mosi(mosi_out),
		.reply(reply), .miso(miso_in), .captured(captured), .bit_count(bit_count));

	// Free-running system clock at 125 MHz.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic timeout(input string what);
		mismatches++;
		$display("[ERR] %0t wait ran out: %s", $time, what);
		results();
	endtask : timeout

	// Samples just after an edge, once its updates have landed.
	task automatic look;
		@(posedge clock);
		#1;
	endtask : look

	task automatic push_n(input int n, input logic [15:0] first);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			fifo_data_wr    <= 1'b1;
			fifo_data_wdata <= first + 16'(i);
		end
		@(posedge clock);
		fifo_data_wr <= 1'b0;
	endtask : push_n

	task automatic pop_n(input int n);
		repeat (n) begin
			@(posedge clock);
			fifo_data_rd <= 1'b1;
		end
		@(posedge clock);
		fifo_data_rd <= 1'b0;
	endtask : pop_n

	task automatic strobe(input int k, input logic v);
		@(posedge clock);
		case (k)
			0: rx_overflow_clear <= v;
			1: rx_underflow_clear <= v;
			2: tx_overflow_clear <= v;
			default: irq_mask_we <= v;
		endcase
	endtask : strobe

	// Busy rises late, so the empty flag is waited on as well.
	task automatic wait_idle;
		int c;
		c = 0;
		repeat (4) look();
		while (!(tx_fifo_empty === 1'b1 && busy === 1'b0)) begin
			look();
			c++;
			if (c > 20000) timeout("idle");
		end
		// The registered selects release one edge after the engine idles.
		look();
	endtask : wait_idle

	// Counts system cycles between two rising serial clock edges.
	task automatic sclk_period(output int p);
		int c;
		int n;
		logic prev;
		c = 0;
		n = 0;
		p = 0;
		prev = sclk_out;
		while (n < 2) begin
			look();
			if (sclk_out === 1'b1 && prev === 1'b0) n++;
			if (n == 1) p++;
			prev = sclk_out;
			c++;
			if (c > 5000) timeout("sclk");
		end
	endtask : sclk_period

	// Main sequence of scenarios.
	initial begin
		{rst, subcpu_cs_n} = {1'b1, 4'hF};
		{controller_enable, irq_mask_we, fifo_data_wr, fifo_data_rd, subcpu_enable} = '0;
		{rx_overflow_clear, rx_underflow_clear, tx_overflow_clear} = '0;
		{transaction_config_reg, rx_frame_count} = {16'h010F, 16'h0000};
		{clock_divisor, cs_select_mask, fifo_data_wdata} = {16'h00FA, 16'h0001, 16'h0000};
		{boot_cs_sel, slave_if_cs_sel, cs_force_enable, cs_force_value} = '0;
		{tx_threshold, rx_threshold, irq_mask_wdata, reply} = {12'h000, 5'h1F, 16'hA5C3};
		{mismatches, check_count} = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		look();
		cmp(cs_pins_n, 16'hFFFF, "cs idle");
		cmp(irq_mask, 16'h001F, "mask reset");
		cmp(raw_irq_status, 16'h0000, "raw reset");
		cmp(irq_out, 1'b0, "irq reset");
		@(posedge clock);
		controller_enable <= 1'b1;
		push_n(2, 16'h1234);
		sclk_period(per);
		cmp(per, 16'd250, "divisor 250");
		wait_idle();
		cmp(bit_count, 16'd32, "one select");
		cmp(captured, 16'h1235, "last frame");
		cmp(rx_fill_level, 6'd0, "tx only");
		cmp(primary_cs_pin_n, 1'b1, "released");
		@(posedge clock);
		transaction_config_reg <= 16'h001F;
		clock_divisor <= 16'h0002;
		push_n(1, 16'h0F0F);
		sclk_period(per);
		cmp(per, 16'd6, "fastest clock");
		wait_idle();
		cmp(captured, 16'h0F0F, "framed out");
		cmp(rx_fill_level, 6'd1, "txrx fill");
		pop_n(1);
		look();
		cmp(fifo_data_rdata, 16'hA5C3, "rx word");
		@(posedge clock);
		{transaction_config_reg, rx_frame_count} <= {16'h0203, 16'd32};
		{rx_threshold, clock_divisor} <= {6'd2, 16'h0006};
		push_n(1, 16'h0000);
		wait_idle();
		look();
		cmp(rx_fill_level, 6'd32, "rx only full");
		cmp(tx_fifo_empty, 1'b1, "start popped");
		cmp(raw_irq_status.rx_ovf, 1'b1, "rx ovf");
		cmp(raw_irq_status.rx_level, 1'b1, "rx level");
		strobe(0, 1'b1);
		strobe(0, 1'b0);
		look();
		cmp(raw_irq_status.rx_ovf, 1'b0, "rx ovf clr");
		pop_n(29);
		look();
		cmp(fifo_data_rdata[15:4], 16'h0000, "4 bit frame");
		cmp(raw_irq_status.rx_level, 1'b1, "fill 3");
		pop_n(1);
		look();
		cmp(raw_irq_status.rx_level, 1'b0, "fill 2");
		pop_n(2);
		pop_n(1);
		look();
		cmp(fifo_data_rdata, 16'h0000, "empty read");
		cmp(raw_irq_status.rx_under, 1'b1, "rx under");
		look();
		cmp(irq_out, 1'b1, "irq on");
		cmp(masked_irq_status, 16'h0004, "masked");
		@(posedge clock);
		irq_mask_wdata <= 5'h1B;
		strobe(3, 1'b1);
		strobe(3, 1'b0);
		look();
		look();
		cmp(irq_mask, 16'h001B, "mask write");
		cmp(masked_irq_status, 16'h0000, "masked off");
		cmp(raw_irq_status.rx_under, 1'b1, "raw kept");
		cmp(irq_out, 1'b0, "irq masked");
		@(posedge clock);
		tx_threshold <= 6'd2;
		look();
		look();
		cmp(raw_irq_status.tx_level, 1'b1, "tx level");
		cmp(irq_out, 1'b1, "tx irq");
		@(posedge clock);
		controller_enable <= 1'b0;
		look();
		look();
		cmp(irq_out, 1'b0, "disabled");
		strobe(1, 1'b1);
		strobe(1, 1'b0);
		look();
		cmp(raw_irq_status.rx_under, 1'b0, "under clr");
		@(posedge clock);
		{transaction_config_reg, clock_divisor} <= {16'h010F, 16'h00FA};
		controller_enable <= 1'b1;
		push_n(34, 16'h0100);
		look();
		cmp(fifo_data_wr_ready, 1'b0, "tx full");
		cmp(tx_fill_level, 6'd32, "tx fill");
		cmp(raw_irq_status.tx_ovf, 1'b1, "tx ovf");
		cmp(raw_irq_status.tx_level, 1'b0, "tx above");
		strobe(2, 1'b1);
		strobe(2, 1'b0);
		look();
		cmp(raw_irq_status.tx_ovf, 1'b0, "tx ovf clr");
		@(posedge clock);
		controller_enable <= 1'b0;
		{boot_cs_sel, slave_if_cs_sel} <= {16'h0004, 16'h0002};
		{cs_force_enable, cs_force_value} <= {16'h000D, 16'h0004};
		{subcpu_enable, subcpu_cs_n} <= {1'b1, 4'b1010};
		exp_cs = (~(16'h0004 | 16'h0002) & ~16'h000D) | (16'h0004 & 16'h000D);
		exp_cs[8:5] = 4'b1010;
		repeat (3) look();
		cmp(busy, 1'b0, "abort");
		cmp(cs_pins_n, exp_cs, "cs share");
		cmp(primary_cs_pin_n, exp_cs[0], "primary");
		@(posedge clock);
		subcpu_enable <= 1'b0;
		exp_cs[8:5] = 4'hF;
		repeat (3) look();
		cmp(cs_pins_n, exp_cs, "subcpu off");
		results();
	end
endmodule : smc_master_tb
